// *** design/adc_back_end.sv ***
// Function
// - Speed mode is single from 2 to 54 kHz, double from 54 to 108 kHz and quad from 108 to 216 kHz.
// - The filter path delays samples by 12, 9 or 5 output sample periods in single, double or quad mode.
// - All filter characteristics scale exactly with the output sample rate.
// - The optional DC-removal high-pass has its -3 dB corner near 1 Hz at 48 kHz.
// - After an overrange the overflow indicator stays set for 2^17-1 sample periods.
// - The serial port is a bit clock, a frame clock and a serial data output.
// - As master in I2S or left-justified format the bit clock is 64 times the sample rate.
// - As master the bit clock duty is 50%, or is one third with the alternate divider.
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_back_end #(
	parameter int OVERFLOW_INDICATOR_HOLD = `ADC_OVERFLOW_INDICATOR_HOLD,
	parameter int HPF_SHIFT = `ADC_HPF_SHIFT
) (
	input  wire logic               i_clk_sys,          // Master clock
	input  wire logic               i_sys_rst,          // Sync reset, high
	input  wire logic [7:0]         i_fs_khz,           // Sample rate in kHz
	input  wire logic               i_master_mode,      // 1: drive clocks
	input  wire logic               i_fmt_i2s,          // 1: I2S, 0: left-justified
	input  wire logic               i_divider_select,   // 1: one-third duty
	input  wire logic               i_hpf_enable,       // DC removal on
	input  wire logic               i_smp_valid,        // New decimated sample pair
	input  wire adc_pkg::adc_sample_t i_smp_left,       // Left sample
	input  wire adc_pkg::adc_sample_t i_smp_right,      // Right sample
	input  wire logic               i_overrange,        // Modulator overrange
	input  wire logic               i_bit_clk,          // Bit clock pin in
	output logic                    o_bit_clk,          // Bit clock pin out
	output logic                    o_bit_clk_oe_n,     // Bit clock drive, low
	input  wire logic               i_frame_clock,      // Frame clock pin in
	output logic                    o_frame_clock,      // Frame clock pin out
	output logic                    o_frame_clock_oe_n, // Frame clock drive, low
	output logic                    o_serial_data_out,  // Serial data
	output logic                    o_overflow_indicator, // Overflow held
	output adc_pkg::adc_speed_t     o_speed_mode        // Current speed mode
);
	import adc_pkg::*;

	// ----------------------------------------
	// Speed mode and delay tap
	// ----------------------------------------
	adc_speed_t next_speed;
	adc_speed_t speed;
	logic [3:0] gd_tap;

	assign next_speed = (i_fs_khz <= `ADC_FS_SINGLE_MAX_KHZ) ? ADC_SPD_SINGLE :
	                    (i_fs_khz <= `ADC_FS_DOUBLE_MAX_KHZ) ? ADC_SPD_DOUBLE : ADC_SPD_QUAD;

	always_comb begin
		case (speed)
			ADC_SPD_SINGLE: gd_tap = `ADC_GD_SINGLE - 4'd1;
			ADC_SPD_DOUBLE: gd_tap = `ADC_GD_DOUBLE - 4'd1;
			ADC_SPD_QUAD:   gd_tap = `ADC_GD_QUAD - 4'd1;
			default:        gd_tap = `ADC_GD_SINGLE - 4'd1;
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst)
			speed <= ADC_SPD_SINGLE;
		else
			speed <= next_speed;
	end

	// ----------------------------------------
	// DC-removal high-pass, per channel
	// ----------------------------------------
	// Fixed shift per sample: the corner is a fraction of Fs, so it scales
	adc_sample_t hpf_out [2];
	adc_sample_t hpf_in  [2];
	assign hpf_in[0] = i_smp_left;
	assign hpf_in[1] = i_smp_right;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_hpf
			logic signed [23+HPF_SHIFT:0] acc;
			logic signed [24:0]           diff;
			logic signed [23:0]           dc;
			assign dc   = 24'(acc >>> HPF_SHIFT);
			assign diff = 25'(hpf_in[ch]) - 25'(dc);
			assign hpf_out[ch] = !i_hpf_enable ? hpf_in[ch] :
			                     (diff[24] != diff[23]) ? {diff[24], {23{~diff[24]}}} : diff[23:0];
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst || !i_hpf_enable)
					acc <= '0;
				else if (i_smp_valid)
					acc <= acc + (24+HPF_SHIFT)'(diff);
			end
		end
	endgenerate

	// ----------------------------------------
	// Group delay line
	// ----------------------------------------
	adc_sample_t dly_l [`ADC_GD_DEPTH];
	adc_sample_t dly_r [`ADC_GD_DEPTH];

	genvar k;
	generate
		for (k = 0; k < `ADC_GD_DEPTH; k++) begin : g_dly
			adc_sample_t src_l;
			adc_sample_t src_r;
			// Head stage feeds from the filter; no index below zero is ever built
			if (k == 0) begin : g_head
				assign src_l = hpf_out[0];
				assign src_r = hpf_out[1];
			end else begin : g_tail
				assign src_l = dly_l[k-1];
				assign src_r = dly_r[k-1];
			end
			always_ff @(posedge i_clk_sys) begin
				if (i_sys_rst) begin
					dly_l[k] <= '0;
					dly_r[k] <= '0;
				end else if (i_smp_valid) begin
					dly_l[k] <= src_l;
					dly_r[k] <= src_r;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Overflow hold
	// ----------------------------------------
	adc_overflow_indicator_if ovf ();
	assign ovf.sample_tick = i_smp_valid;
	assign ovf.overrange   = i_overrange;
	assign o_overflow_indicator = ovf.flag;

	adc_overflow_indicator_timer #(.HOLD(OVERFLOW_INDICATOR_HOLD)) u_overflow_indicator (
		.i_clk_sys (i_clk_sys),
		.i_sys_rst (i_sys_rst),
		.ovf       (ovf.timer)
	);

	// ----------------------------------------
	// Pin synchronisers for slave clocks
	// ----------------------------------------
	logic bclk_s1, bclk_s2, bclk_s3;
	logic fclk_s1, fclk_s2;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			bclk_s1 <= 1'b0;
			bclk_s2 <= 1'b0;
			bclk_s3 <= 1'b0;
			fclk_s1 <= 1'b0;
			fclk_s2 <= 1'b0;
		end else begin
			bclk_s1 <= i_bit_clk;
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			fclk_s1 <= i_frame_clock;
			fclk_s2 <= fclk_s1;
		end
	end

	// ----------------------------------------
	// Master bit clock divider
	// ----------------------------------------
	// High for one master cycle: 50% at divide-by-2, 33% at divide-by-3
	logic [1:0] div_cnt;
	logic [1:0] div_per;
	logic [1:0] next_div;
	logic       bclk_gen;

	assign div_per  = i_divider_select ? `ADC_DIV_THIRD : `ADC_DIV_EVEN;
	assign next_div = (div_cnt >= div_per - 2'd1) ? 2'd0 : div_cnt + 2'd1;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || !i_master_mode) begin
			div_cnt  <= 2'd0;
			bclk_gen <= 1'b0;
		end else begin
			div_cnt  <= next_div;
			bclk_gen <= (next_div == 2'd0);
		end
	end

	// ----------------------------------------
	// Serializer
	// ----------------------------------------
	logic       fall;
	logic       frame_lvl;
	logic       frame_prev;
	logic       frame_edge;
	logic       half;
	logic [4:0] pos;
	logic       next_half;
	logic [4:0] next_pos;
	logic        word_start;
	logic [31:0] slot;
	adc_sample_t word_l;
	adc_sample_t word_r;
	adc_sample_t cur_word;
	logic       sdata;
	logic       fout;

	// Shift events only on the falling bit clock edge
	assign fall = i_master_mode ? bclk_gen : (bclk_s3 && !bclk_s2);
	assign frame_lvl  = fclk_s2;
	assign frame_edge = (frame_lvl != frame_prev);

	// Master counts 64 bit clocks per frame; slave resyncs on each frame edge
	assign {next_half, next_pos} = i_master_mode ? {half, pos} + 6'd1 :
	                               frame_edge ? {frame_lvl ^ ~i_fmt_i2s, 5'd0} :
	                               (pos == 5'd31) ? {half, pos} : {half, pos} + 6'd1;

	assign word_start = !next_half && (next_pos == 5'd0);
	// Left word latches on the edge its first bit leaves, so bypass the latch then
	assign cur_word   = word_start ? dly_l[gd_tap] : (next_half ? word_r : word_l);
	// I2S lags the frame edge by one bit; LJ starts on it; spare slot bits are 0
	assign slot       = i_fmt_i2s ? {1'b0, cur_word, 7'h00} : {cur_word, 8'h00};

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			half       <= 1'b1;
			pos        <= 5'd31;
			frame_prev <= 1'b0;
			word_l     <= '0;
			word_r     <= '0;
			sdata      <= 1'b0;
			fout       <= 1'b0;
		end else if (fall) begin
			half       <= next_half;
			pos        <= next_pos;
			frame_prev <= frame_lvl;
			sdata      <= slot[5'd31 - next_pos];
			fout       <= next_half ^ ~i_fmt_i2s;
			if (word_start) begin
				word_l <= dly_l[gd_tap];
				word_r <= dly_r[gd_tap];
			end
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	assign o_bit_clk          = bclk_gen;
	assign o_bit_clk_oe_n     = ~i_master_mode;
	assign o_frame_clock      = fout;
	assign o_frame_clock_oe_n = ~i_master_mode;
	assign o_serial_data_out  = sdata;
	assign o_speed_mode       = speed;
endmodule : adc_back_end

// *** design/adc_defs.svh ***
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ----------------------------------------
// Speed mode sample-rate limits (kHz)
// ----------------------------------------
`define ADC_FS_SINGLE_MAX_KHZ 8'd54
`define ADC_FS_DOUBLE_MAX_KHZ 8'd108
`define ADC_FS_QUAD_MAX_KHZ   8'd216

// ----------------------------------------
// Group delay in output sample periods
// ----------------------------------------
`define ADC_GD_SINGLE 4'd12
`define ADC_GD_DOUBLE 4'd9
`define ADC_GD_QUAD   4'd5
`define ADC_GD_DEPTH  12

// ----------------------------------------
// High-pass filter
// ----------------------------------------
`define ADC_HPF_SHIFT 13

// ----------------------------------------
// Overflow hold, in sample periods
// ----------------------------------------
`define ADC_OVERFLOW_INDICATOR_HOLD 131071
`define ADC_OVERFLOW_INDICATOR_W    17

// ----------------------------------------
// Serial port framing
// ----------------------------------------
`define ADC_WORD_W      24
`define ADC_BCLK_PER_FS 64
`define ADC_DIV_EVEN    2'd2
`define ADC_DIV_THIRD   2'd3

`endif

// *** design/adc_pkg.sv ***
package adc_pkg;
	typedef enum logic [2:0] {
		ADC_SPD_SINGLE = 3'b001,
		ADC_SPD_DOUBLE = 3'b010,
		ADC_SPD_QUAD   = 3'b100
	} adc_speed_t;

	typedef logic signed [23:0] adc_sample_t;
endpackage : adc_pkg

// *** design/adc_overflow_indicator_if.sv ***
`timescale 1ns/1ps
interface adc_overflow_indicator_if;
	logic sample_tick;
	logic overrange;
	logic flag;

	modport owner (output sample_tick, output overrange, input flag);
	modport timer (input sample_tick, input overrange, output flag);
endinterface : adc_overflow_indicator_if

// *** design/adc_overflow_indicator_timer.sv ***
`timescale 1ns/1ps
`include "adc_defs.svh"
module adc_overflow_indicator_timer #(
	parameter int HOLD = `ADC_OVERFLOW_INDICATOR_HOLD
) (
	input  wire logic  i_clk_sys, // System clock
	input  wire logic  i_sys_rst, // Sync reset, high
	adc_overflow_indicator_if.timer  ovf        // Overrange in, flag out
);
	logic [`ADC_OVERFLOW_INDICATOR_W-1:0] cnt;
	logic [`ADC_OVERFLOW_INDICATOR_W-1:0] next_cnt;
	logic                   flag;

	// Overrange reloads even while counting down: a fresh event wins
	assign next_cnt = ovf.overrange ? HOLD[`ADC_OVERFLOW_INDICATOR_W-1:0] :
	                  (ovf.sample_tick && cnt != '0) ? cnt - 1'b1 : cnt;

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			cnt  <= '0;
			flag <= 1'b0;
		end else begin
			cnt  <= next_cnt;
			flag <= (next_cnt != '0);
		end
	end

	assign ovf.flag = flag;
endmodule : adc_overflow_indicator_timer

// *** dv/adc_host_model.sv ***
`timescale 1ns/1ps
module adc_host_model (
	input  wire logic   i_clk_sys, // Master clock
	input  wire logic   i_run,     // Host makes clocks
	input  wire logic   i_fmt_i2s, // I2S framing
	input  wire logic   i_bclk,    // Bit clock wire
	input  wire logic   i_fclk,    // Frame clock wire
	input  wire logic   i_sdata,   // Data wire
	output logic        o_bclk,    // Host bit clock
	output logic        o_fclk,    // Host frame clock
	output logic [23:0] o_left,    // Left word
	output logic [23:0] o_right,   // Right word
	output int          o_frames   // Frames taken
);
	// Host is never reset; it locks on to the first frame edge it sees
	logic [9:0]  cnt  = 10'h0;
	logic [31:0] sh   = 32'h0;
	logic        half = 1'b0;
	// Slow 16-cycle bit clock leaves time for the pin synchronisers
	always @(posedge i_clk_sys) cnt <= i_run ? cnt + 10'h1 : 10'h0;
	assign o_bclk = cnt[3];
	assign o_fclk = cnt[9] ^ !i_fmt_i2s;
	always @(posedge i_bclk) begin
		if ((i_fclk ^ i_fmt_i2s) != half) begin
			sh <= {31'h0, i_sdata};
			if (half) o_left <= i_fmt_i2s ? sh[30:7] : sh[31:8];
			else o_right <= i_fmt_i2s ? sh[30:7] : sh[31:8];
			o_frames <= o_frames + int'(!half);
		end else sh <= {sh[30:0], i_sdata};
		half <= i_fclk ^ i_fmt_i2s;
	end
endmodule : adc_host_model

// *** dv/adc_back_end_assertions.sv ***
`timescale 1ns/1ps
module adc_back_end_assertions
	import adc_pkg::*;
(
	input wire logic       i_clk_sys,            // Clock
	input wire logic       i_sys_rst,            // Reset
	input wire logic [7:0] i_fs_khz,             // Rate
	input wire logic       i_master_mode,        // Master
	input wire logic       i_divider_select,     // Third duty
	input wire logic       i_smp_valid,          // Tick
	input wire logic       i_overrange,          // Overrange
	input wire logic       o_bit_clk,            // Bit clock
	input wire logic       o_bit_clk_oe_n,       // Drive
	input wire logic       o_frame_clock,        // Frame clock
	input wire logic       o_frame_clock_oe_n,   // Drive
	input wire logic       o_serial_data_out,    // Data
	input wire logic       o_overflow_indicator, // Flag
	input wire adc_speed_t o_speed_mode          // Speed
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	chk_speed_single: assert property (i_fs_khz <= 8'h36 |=> o_speed_mode == ADC_SPD_SINGLE)
		else $error("speed not single");
	chk_speed_double: assert property (i_fs_khz > 8'h36 && i_fs_khz <= 8'h6c |=> o_speed_mode == ADC_SPD_DOUBLE)
		else $error("speed not double");
	chk_speed_quad: assert property (i_fs_khz > 8'h6c |=> o_speed_mode == ADC_SPD_QUAD)
		else $error("speed not quad");
	chk_overflow_indicator_set: assert property (i_overrange |=> o_overflow_indicator)
		else $error("overflow not set");
	chk_overflow_indicator_hold: assert property (o_overflow_indicator && !i_smp_valid && !i_overrange |=> o_overflow_indicator)
		else $error("overflow dropped without tick");
	chk_pin_dir: assert property (o_bit_clk_oe_n == !i_master_mode && o_frame_clock_oe_n == !i_master_mode)
		else $error("pin drive wrong");
	chk_bclk_half: assert property ($fell(o_bit_clk) && !i_divider_select |=> o_bit_clk)
		else $error("bit clock period not 2");
	chk_bclk_third: assert property ($fell(o_bit_clk) && i_divider_select |=> !o_bit_clk ##1 o_bit_clk)
		else $error("bit clock period not 3");
	chk_bclk_pulse: assert property (o_bit_clk |=> !o_bit_clk)
		else $error("bit clock high too long");
	chk_fall_align: assert property (i_master_mode && !$fell(o_bit_clk) |->
		$stable(o_frame_clock) && $stable(o_serial_data_out))
		else $error("frame or data moved off falling edge");
	cov_overflow_indicator_clear: cover property ($fell(o_overflow_indicator));
	cov_third: cover property ($fell(o_bit_clk) && i_divider_select);
	cov_slave: cover property (!i_master_mode && o_serial_data_out);
endmodule : adc_back_end_assertions
bind adc_back_end adc_back_end_assertions u_chk (
	.i_clk_sys            (i_clk_sys),
	.i_sys_rst            (i_sys_rst),
	.i_fs_khz             (i_fs_khz),
	.i_master_mode        (i_master_mode),
	.i_divider_select     (i_divider_select),
	.i_smp_valid          (i_smp_valid),
	.i_overrange          (i_overrange),
	.o_bit_clk            (o_bit_clk),
	.o_bit_clk_oe_n       (o_bit_clk_oe_n),
	.o_frame_clock        (o_frame_clock),
	.o_frame_clock_oe_n   (o_frame_clock_oe_n),
	.o_serial_data_out    (o_serial_data_out),
	.o_overflow_indicator (o_overflow_indicator),
	.o_speed_mode         (o_speed_mode)
);

// *** dv/adc_back_end_tb.sv ***
`timescale 1ns/1ps
module adc_back_end_tb;
	import adc_pkg::*;
	localparam int HOLD = 7;
	// Short DC-removal time constant so settling fits in the run
	localparam int HPF  = 2;
	logic        i_clk_sys, i_sys_rst, i_master_mode, i_fmt_i2s, i_divider_select;
	logic        i_hpf_enable, i_smp_valid, i_overrange, h_bclk, h_fclk;
	logic [7:0]  i_fs_khz;
	adc_sample_t i_smp_left, i_smp_right;
	logic        o_bit_clk, o_bit_clk_oe_n, o_frame_clock, o_frame_clock_oe_n;
	logic        o_serial_data_out, o_overflow_indicator;
	adc_speed_t  o_speed_mode;
	logic [23:0] h_left, h_right;
	int          h_frames, errors, total_checks, cycles;
	wire         i_bit_clk = o_bit_clk_oe_n ? h_bclk : o_bit_clk;
	wire         i_frame_clock = o_frame_clock_oe_n ? h_fclk : o_frame_clock;
	adc_back_end #(.OVERFLOW_INDICATOR_HOLD(HOLD), .HPF_SHIFT(HPF)) DUT (
		.i_clk_sys            (i_clk_sys),
		.i_sys_rst            (i_sys_rst),
		.i_fs_khz             (i_fs_khz),
		.i_master_mode        (i_master_mode),
		.i_fmt_i2s            (i_fmt_i2s),
		.i_divider_select     (i_divider_select),
		.i_hpf_enable         (i_hpf_enable),
		.i_smp_valid          (i_smp_valid),
		.i_smp_left           (i_smp_left),
		.i_smp_right          (i_smp_right),
		.i_overrange          (i_overrange),
		.i_bit_clk            (i_bit_clk),
		.o_bit_clk            (o_bit_clk),
		.o_bit_clk_oe_n       (o_bit_clk_oe_n),
		.i_frame_clock        (i_frame_clock),
		.o_frame_clock        (o_frame_clock),
		.o_frame_clock_oe_n   (o_frame_clock_oe_n),
		.o_serial_data_out    (o_serial_data_out),
		.o_overflow_indicator (o_overflow_indicator),
		.o_speed_mode         (o_speed_mode)
	);
	adc_host_model host (.i_clk_sys(i_clk_sys), .i_run(!i_master_mode), .i_fmt_i2s(i_fmt_i2s),
		.i_bclk(i_bit_clk), .i_fclk(i_frame_clock), .i_sdata(o_serial_data_out), .o_bclk(h_bclk),
		.o_fclk(h_fclk), .o_left(h_left), .o_right(h_right), .o_frames(h_frames));
	initial begin
		i_clk_sys = 0;
		forever #5 i_clk_sys = ~i_clk_sys;
	end
	// Streams in slave mode dominate, about 60k cycles in all
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic tick(int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask : tick
	task automatic setup(logic m, logic f, logic d);
		i_sys_rst = 1;
		i_master_mode = m;
		i_fmt_i2s = f;
		i_divider_select = d;
		tick(6);
		i_sys_rst = 0;
	endtask : setup
	task automatic smp(adc_sample_t l, adc_sample_t r);
		i_smp_valid = 1;
		i_smp_left = l;
		i_smp_right = r;
		tick(1);
		i_smp_valid = 0;
		tick(1);
	endtask : smp
	task automatic frame(adc_sample_t l, adc_sample_t r);
		int k;
		k = h_frames;
		for (int c = 0; c < 2000 && h_frames == k; c++) tick(1);
		smp(l, r);
	endtask : frame
	task automatic t_speed();
		logic [7:0] f [6] = '{8'h02, 8'h36, 8'h37, 8'h6c, 8'h6d, 8'hd8};
		foreach (f[i]) begin
			i_fs_khz = f[i];
			tick(2);
			check(o_speed_mode, 32'h1 << (i / 2));
		end
	endtask : t_speed
	task automatic t_overflow_indicator();
		i_overrange = 1;
		tick(1);
		i_overrange = 0;
		check(o_overflow_indicator, 1);
		repeat (4) smp('0, '0);
		i_overrange = 1;
		tick(1);
		i_overrange = 0;
		repeat (HOLD - 1) smp('0, '0);
		check(o_overflow_indicator, 1);
		smp('0, '0);
		tick(1);
		check(o_overflow_indicator, 0);
	endtask : t_overflow_indicator
	task automatic t_clk(logic d);
		int n, hi;
		logic p;
		setup(1'b1, 1'b0, d);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			hi = 0;
			do begin
				p = o_frame_clock;
				tick(1);
				n++;
				hi += int'(o_bit_clk);
			end while (!(p === 1'b0 && o_frame_clock === 1'b1) && n < 400);
		end
		check(n, d ? 32'hc0 : 32'h80);
		check(hi, 32'h40);
	endtask : t_clk
	task automatic t_stream(logic m, logic f, logic d, logic [7:0] r, int dly);
		int n;
		setup(m, f, d);
		i_fs_khz = r;
		repeat (dly + 4) frame(24'h5a3c71, 24'ha1b2c3);
		check(h_left, 24'h5a3c71);
		check(h_right, 24'ha1b2c3);
		n = 0;
		do begin
			frame(24'h8e01f4, 24'h17d6e9);
			n++;
		end while (h_left !== 24'h8e01f4 && n < 20);
		check(n, dly + 2);
	endtask : t_stream
	task automatic t_hpf();
		int n;
		setup(1'b1, 1'b0, 1'b0);
		i_fs_khz = 8'h30;
		i_hpf_enable = 1'b1;
		repeat (14) frame(24'h400000, 24'hc00000);
		check(h_left, 24'h400000);
		n = 0;
		do begin
			frame(24'h400000, 24'hc00000);
			n++;
		end while (h_left !== 24'h0 && n < 150);
		check(h_left, 24'h0);
		check(h_right, 24'h0);
		i_hpf_enable = 1'b0;
	endtask : t_hpf
	initial begin
		{i_smp_valid, i_overrange, i_hpf_enable} = 3'h0;
		{i_smp_left, i_smp_right} = '0;
		i_fs_khz = 8'h30;
		{errors, total_checks} = '0;
		setup(1'b1, 1'b0, 1'b0);
		t_speed();
		t_overflow_indicator();
		t_clk(1'b0);
		t_clk(1'b1);
		t_stream(1'b1, 1'b0, 1'b0, 8'h30, 12);
		t_stream(1'b1, 1'b1, 1'b1, 8'h60, 9);
		t_hpf();
		t_stream(1'b0, 1'b1, 1'b0, 8'hc0, 5);
		t_stream(1'b0, 1'b0, 1'b0, 8'h60, 9);
		complete_run();
	end
endmodule : adc_back_end_tb
